//--- logic/lecb_defs.svh
// Constants for the link engine command and acknowledgment buffer front end
`ifndef LECB_DEFS_SVH
`define LECB_DEFS_SVH
`define LECB_QUEUE_CMD_MIN 8'h80
`define LECB_CMD_HALT_NOW 8'h01
`define LECB_CMD_DEMODULATOR_TEST 8'h02
`define LECB_CMD_RX_TEST 8'h03
`define LECB_CMD_TX_ZERO_TEST 8'h04
`define LECB_CMD_TX_QUEUE_TEST 8'h05
`define LECB_CMD_PING 8'h06
`define LECB_CMD_RX 8'h08
`define LECB_CMD_TX 8'h09
`define LECB_CMD_TX_CLEAR_CHANNEL 8'h0a
`define LECB_CMD_STOP 8'h0b
`define LECB_CMD_TIMER_EVENT_ONE 8'h21
`define LECB_CMD_TIMER_EVENT_TWO 8'h22
`define LECB_CMD_FLUSH_FIRST 8'h30
`define LECB_CMD_FLUSH_LAST 8'h37
`define LECB_MODE_PROPRIETARY 2'h0
`define LECB_MODE_LOW_ENERGY 2'h1
`define LECB_MODE_RESET 2'h0
`define LECB_LEN_FREE 6'h00
`define LECB_LEN_MAX 6'h20
`define LECB_PAGE_LOW_ENTRIES 3'h7
`define LECB_BUF_STEP 16'h0020
`define LECB_BUF_BASE 16'h6000
`define LECB_QUEUE_WINDOW_BASE 16'h6100
`endif

//--- logic/lecb_pkg.sv
// Types shared by the link engine command and acknowledgment buffer front end
package lecb_pkg;
  typedef enum logic [2:0] {
    LECB_TASK_NONE,
    LECB_TASK_DEMOD_TEST,
    LECB_TASK_RX_TEST,
    LECB_TASK_TX_ZERO_TEST,
    LECB_TASK_TX_QUEUE_TEST,
    LECB_TASK_RX,
    LECB_TASK_TX,
    LECB_TASK_TX_CLEAR_CHANNEL
  } lecb_task_t;
  // Host write of a length register
  typedef struct packed {
    logic valid;
    logic [2:0] entry;
    logic buffer;
    logic [5:0] length;
  } lecb_len_write_t;
  // Pulsed notifications toward the host processor
  typedef struct packed {
    logic transmitComplete;
    logic ackFlushComplete;
    logic engineError;
    logic pingReply;
    logic packetAbort;
  } lecb_irq_t;
endpackage : lecb_pkg

//--- logic/lecb_link_engine.sv
// Link engine command interpreter with per-address acknowledgment buffers
`include "lecb_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module lecb_link_engine
  import lecb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Engine control register
  input wire logic ctrlWrite,
  input wire logic engineEnableIn,
  input wire logic [1:0] engineModeIn,
  output logic engineEnable,
  output logic [1:0] engineModeSelect,
  // Command register
  input wire logic cmdWrite,
  input wire logic [7:0] cmdData,
  output logic [7:0] commandReg,
  output logic queueCmdValid,
  output logic [7:0] queueCmd,
  // Task state and radio status
  input wire logic autoMode,
  input wire logic packetActive,
  input wire logic taskFinished,
  input wire logic ramLockOneFree,
  output logic [2:0] currentTask,
  output logic taskRunning,
  output logic radioAllowed,
  output logic timerEventOne,
  output logic timerEventTwo,
  output logic stopRequest,
  // Ack payload transmission from the radio
  input wire logic ackTxStart,
  input wire logic ackTxDone,
  input wire logic [2:0] ackTxEntry,
  output logic ackSourceBuffers,
  output logic [15:0] ackBufAddr,
  output logic [2:0] ackBufPage,
  output logic [5:0] ackBufLen,
  // Length register access by host
  input wire lecb_len_write_t lenWrite,
  input wire logic [2:0] lenReadEntry,
  output logic [5:0] lenRead0,
  output logic [5:0] lenRead1,
  output logic nextAckRead,
  output logic payloadSentRead,
  // Interrupt pulses
  output lecb_irq_t irq
);

  // Per-entry buffer state
  logic [5:0] len0 [8];
  logic [5:0] len1 [8];
  logic [7:0] next_ack_buffer;
  logic [7:0] payloadSent;
  // Task and enable history
  lecb_task_t task_q;
  logic prevEnable;
  // Ack in flight
  logic ackBusy;
  logic [2:0] ackEntry;
  // Flush sequencing
  logic flushPending;
  logic [2:0] flushEntry;
  logic flushLocked;

  // Buffer start address inside the page or window for entry and slot
  // Entries pair up on a page; the odd entry takes the upper 64 bytes
  function automatic logic [15:0] buf_addr(input logic [2:0] entry, input logic slot);
    logic [15:0] idx;
    idx = {14'h0000, entry[0], slot};
    buf_addr = `LECB_BUF_BASE + idx * `LECB_BUF_STEP;
  endfunction : buf_addr

  // Page that holds an entry; entries 0 and 1 sit in page 7
  // The queue window alias of entries 0 and 1 needs no decode here
  function automatic logic [2:0] buf_page(input logic [2:0] entry);
    buf_page = (entry[2:1] == 2'h0) ? `LECB_PAGE_LOW_ENTRIES : {1'b0, entry[2:1]};
  endfunction : buf_page

  // Lengths above the buffer size break the host contract; clip so reads stay sane
  function automatic logic [5:0] clip_len(input logic [5:0] len);
    clip_len = (len > `LECB_LEN_MAX) ? `LECB_LEN_MAX : len;
  endfunction : clip_len

  // Engine codes with a defined meaning; every other engine code is an error
  function automatic logic known_code(input logic [7:0] c);
    case (c)
      `LECB_CMD_HALT_NOW, `LECB_CMD_PING, `LECB_CMD_STOP: known_code = 1'b1;
      `LECB_CMD_DEMODULATOR_TEST, `LECB_CMD_RX_TEST: known_code = 1'b1;
      `LECB_CMD_TX_ZERO_TEST, `LECB_CMD_TX_QUEUE_TEST: known_code = 1'b1;
      `LECB_CMD_RX, `LECB_CMD_TX, `LECB_CMD_TX_CLEAR_CHANNEL: known_code = 1'b1;
      `LECB_CMD_TIMER_EVENT_ONE, `LECB_CMD_TIMER_EVENT_TWO: known_code = 1'b1;
      default: known_code = (c >= `LECB_CMD_FLUSH_FIRST) && (c <= `LECB_CMD_FLUSH_LAST);
    endcase
  endfunction : known_code

  // Command decode
  // Decode reads the held register, so a write always lands before it acts
  wire logic enabled = engineEnable;
  wire logic isQueueCmd = cmdData >= `LECB_QUEUE_CMD_MIN;
  wire logic engineTake = (commandReg != 8'h00) && enabled;
  wire logic [7:0] cmd = commandReg;
  wire logic isHalt = cmd == `LECB_CMD_HALT_NOW;
  wire logic isPing = cmd == `LECB_CMD_PING;
  wire logic isStop = cmd == `LECB_CMD_STOP;
  wire logic isEv1 = cmd == `LECB_CMD_TIMER_EVENT_ONE;
  wire logic isEv2 = cmd == `LECB_CMD_TIMER_EVENT_TWO;
  wire logic isFlush = cmd >= `LECB_CMD_FLUSH_FIRST && cmd <= `LECB_CMD_FLUSH_LAST;
  wire logic isTaskCmd = (cmd >= `LECB_CMD_DEMODULATOR_TEST && cmd <= `LECB_CMD_TX_QUEUE_TEST)
    || (cmd >= `LECB_CMD_RX && cmd <= `LECB_CMD_TX_CLEAR_CHANNEL);
  wire logic isUndefined = !known_code(cmd);
  wire logic endNow = engineTake && (isHalt || isUndefined || isTaskCmd);
  // A flush behind an ack on the air for its entry stays in the register
  wire logic flushCmd = engineTake && isFlush;
  wire logic flushWaits = ackBusy && ackEntry == cmd[2:0];
  // Only an ack that was started from the buffers can release one
  wire logic ackRelease = ackBusy && ackTxDone;

  // Task code selected by a starting command
  lecb_task_t next_task;
  always_comb begin
    case (cmd)
      `LECB_CMD_DEMODULATOR_TEST: next_task = LECB_TASK_DEMOD_TEST;
      `LECB_CMD_RX_TEST: next_task = LECB_TASK_RX_TEST;
      `LECB_CMD_TX_ZERO_TEST: next_task = LECB_TASK_TX_ZERO_TEST;
      `LECB_CMD_TX_QUEUE_TEST: next_task = LECB_TASK_TX_QUEUE_TEST;
      `LECB_CMD_RX: next_task = LECB_TASK_RX;
      `LECB_CMD_TX: next_task = LECB_TASK_TX;
      `LECB_CMD_TX_CLEAR_CHANNEL: next_task = LECB_TASK_TX_CLEAR_CHANNEL;
      default: next_task = LECB_TASK_NONE;
    endcase
  end

  // Control register; mode frozen while enabled so a switch needs a disable write first
  // Disable then enable clears engine state through engineReset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      engineEnable <= 1'b0;
      engineModeSelect <= `LECB_MODE_RESET;
      prevEnable <= 1'b0;
    end else begin
      prevEnable <= engineEnable;
      if (ctrlWrite) begin
        engineEnable <= engineEnableIn;
        if (!engineEnable) begin
          engineModeSelect <= engineModeIn;
        end
      end
    end
  end

  // Engine state is cleared whenever the enable bit is low
  // Trade-off: lengths and flags are lost on every disable, not only on reset
  wire logic engineReset = !rst_n || !engineEnable;

  // Command register: queue codes pass on, engine codes wait to be taken
  // A new engine write beats the take; the host waits for zero before one
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      commandReg <= 8'h00;
      queueCmdValid <= 1'b0;
      queueCmd <= 8'h00;
    end else begin
      queueCmdValid <= cmdWrite && isQueueCmd;
      if (cmdWrite && isQueueCmd) begin
        queueCmd <= cmdData;
      end
      if (cmdWrite && !isQueueCmd) begin
        commandReg <= cmdData;
      end else if (engineTake && !(isFlush && (flushPending || flushWaits))) begin
        commandReg <= 8'h00;
      end
    end
  end

  // Task state and pulses toward the radio
  // Stop only asks for an end; the task clears when the radio reports taskFinished
  always_ff @(posedge mclk) begin
    if (engineReset) begin
      task_q <= LECB_TASK_NONE;
      timerEventOne <= 1'b0;
      timerEventTwo <= 1'b0;
      stopRequest <= 1'b0;
    end else begin
      timerEventOne <= engineTake && isEv1;
      timerEventTwo <= engineTake && isEv2;
      stopRequest <= engineTake && isStop;
      if (endNow) begin
        task_q <= next_task;
      end else if (taskFinished) begin
        task_q <= LECB_TASK_NONE;
      end
    end
  end

  // Ack transmission tracking and flush sequencing
  always_ff @(posedge mclk) begin
    if (engineReset) begin
      ackBusy <= 1'b0;
      ackEntry <= 3'h0;
      flushPending <= 1'b0;
      flushEntry <= 3'h0;
      flushLocked <= 1'b0;
    end else begin
      if (ackTxStart && ackSourceBuffers) begin
        ackBusy <= 1'b1;
        ackEntry <= ackTxEntry;
      end else if (ackTxDone) begin
        ackBusy <= 1'b0;
      end
      // Lock outcome is kept from the take, so a later task start cannot alter it
      if (flushCmd && !flushPending && !flushWaits) begin
        flushPending <= 1'b1;
        flushEntry <= cmd[2:0];
        flushLocked <= taskRunning || ramLockOneFree;
      end else if (flushPending) begin
        flushPending <= 1'b0;
      end
    end
  end

  // Interrupt pulses, kept in one register so every field has a single driver
  // Each lasts one cycle; the host must latch it in its own flags
  always_ff @(posedge mclk) begin
    if (engineReset) begin
      irq <= '0;
    end else begin
      irq.transmitComplete <= ackRelease;
      irq.ackFlushComplete <= flushPending;
      irq.engineError <= engineTake && isUndefined;
      irq.pingReply <= engineTake && isPing;
      irq.packetAbort <= endNow && packetActive && task_q != LECB_TASK_NONE;
    end
  end

  // Buffer lengths and flags, one slice per address entry
  // Flush beats release, and release beats a host write on the same entry
  generate
    for (genvar n = 0; n < 8; n++) begin : g_entry
      wire logic hostW = lenWrite.valid && lenWrite.entry == n;
      wire logic flushHit = flushPending && flushEntry == n;
      wire logic relHit = ackRelease && ackEntry == n;
      always_ff @(posedge mclk) begin
        if (engineReset) begin
          len0[n] <= `LECB_LEN_FREE;
          len1[n] <= `LECB_LEN_FREE;
          next_ack_buffer[n] <= 1'b0;
          payloadSent[n] <= 1'b0;
        end else if (flushHit) begin
          len0[n] <= `LECB_LEN_FREE;
          len1[n] <= `LECB_LEN_FREE;
          if (flushLocked) begin
            payloadSent[n] <= 1'b0;
          end
        end else if (relHit) begin
          // Released slot goes free and the other slot is next
          if (next_ack_buffer[n]) begin
            len1[n] <= `LECB_LEN_FREE;
          end else begin
            len0[n] <= `LECB_LEN_FREE;
          end
          next_ack_buffer[n] <= !next_ack_buffer[n];
          payloadSent[n] <= 1'b1;
        end else if (hostW) begin
          // Lengths above the buffer size are clipped, never stored
          if (lenWrite.buffer) begin
            len1[n] <= clip_len(lenWrite.length);
          end else begin
            len0[n] <= clip_len(lenWrite.length);
          end
        end
      end
    end
  endgenerate

  // Ack payload source for the current receive task
  // Receive test counts as a receive task; an ack on the air keeps its entry
  wire logic rxTask = task_q == LECB_TASK_RX || task_q == LECB_TASK_RX_TEST;
  wire logic [2:0] selEntry = ackBusy ? ackEntry : ackTxEntry;
  wire logic selSlot = next_ack_buffer[selEntry];
  wire logic [5:0] selLen = selSlot ? len1[selEntry] : len0[selEntry];

  // Registered outputs toward radio and host
  // Host reads through these registers lag the index by one cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      currentTask <= 3'h0;
      taskRunning <= 1'b0;
      radioAllowed <= 1'b0;
      ackSourceBuffers <= 1'b0;
      ackBufAddr <= `LECB_BUF_BASE;
      ackBufPage <= 3'h0;
      ackBufLen <= `LECB_LEN_FREE;
      lenRead0 <= `LECB_LEN_FREE;
      lenRead1 <= `LECB_LEN_FREE;
      nextAckRead <= 1'b0;
      payloadSentRead <= 1'b0;
    end else begin
      currentTask <= task_q;
      taskRunning <= task_q != LECB_TASK_NONE;
      radioAllowed <= engineEnable && prevEnable;
      ackSourceBuffers <= engineEnable && rxTask && autoMode;
      ackBufAddr <= buf_addr(selEntry, selSlot);
      ackBufPage <= buf_page(selEntry);
      ackBufLen <= selLen;
      lenRead0 <= len0[lenReadEntry];
      lenRead1 <= len1[lenReadEntry];
      nextAckRead <= next_ack_buffer[lenReadEntry];
      payloadSentRead <= payloadSent[lenReadEntry];
    end
  end

endmodule : lecb_link_engine
`default_nettype wire

//--- sim/lecb_chk.sv
// Assertion checker for the link engine front end
`timescale 1ns/100ps
`default_nettype none
module lecb_chk
  import lecb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control and command
  input wire logic ctrlWrite,
  input wire logic engineEnableIn,
  input wire logic engineEnable,
  input wire logic [1:0] engineModeSelect,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdData,
  input wire logic [7:0] commandReg,
  input wire logic queueCmdValid,
  input wire logic [7:0] queueCmd,
  // Task and ack traffic
  input wire logic packetActive,
  input wire logic taskRunning,
  input wire logic ackTxStart,
  input wire logic ackTxDone,
  input wire lecb_irq_t irq
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Ack in flight; a flush behind it may legally wait
  logic ackBusy;
  logic wasEn;
  always_ff @(posedge mclk) begin
    wasEn <= rst_n && engineEnable;
    if (!rst_n) ackBusy <= 1'b0;
    else if (ackTxStart) ackBusy <= 1'b1;
    else if (ackTxDone) ackBusy <= 1'b0;
  end
  // Engine settled on, and decoded command classes
  wire logic live = wasEn && engineEnable;
  wire logic flushWr = cmdWrite && cmdData[7:3] == 5'h06;
  wire logic badCode = commandReg != 8'h00 && !commandReg[7] && !(commandReg inside
    {[8'h01:8'h06], [8'h08:8'h0b], 8'h21, 8'h22, [8'h30:8'h37]});
  chk_enable_follow: assert property (
    ctrlWrite |=> engineEnable == $past(engineEnableIn)) else $error("enable not updated");
  chk_mode_locked: assert property (
    engineEnable |=> $stable(engineModeSelect)) else $error("mode changed while enabled");
  chk_queue_route: assert property (
    cmdWrite |=> queueCmdValid == $past(cmdData[7]) && (!queueCmdValid || queueCmd == $past(cmdData)))
    else $error("queue routing wrong");
  chk_cmd_held: assert property (
    !engineEnable && !cmdWrite && !ctrlWrite |=> $stable(commandReg)) else $error("command lost");
  chk_bad_code: assert property (
    live && badCode |=> irq.engineError && commandReg == 8'h00) else $error("no engine error");
  chk_bad_abort: assert property (
    live && badCode && taskRunning && packetActive |=> irq.packetAbort) else $error("no abort");
  chk_flush_done: assert property (
    flushWr && engineEnable && commandReg == 8'h00 && !ackBusy && !ackTxStart
    |-> ##3 irq.ackFlushComplete) else $error("flush not completed");
  chk_release_irq: assert property (
    ackTxDone && ackBusy |=> irq.transmitComplete) else $error("release without irq");
  // Main scenarios reached
  cover property (irq.ackFlushComplete);
  cover property (irq.transmitComplete);
  cover property (live && badCode && taskRunning && packetActive);
endmodule : lecb_chk
bind lecb_link_engine lecb_chk chk (.mclk, .rst_n, .ctrlWrite, .engineEnableIn, .engineEnable,
  .engineModeSelect, .cmdWrite, .cmdData, .commandReg, .queueCmdValid, .queueCmd,
  .packetActive, .taskRunning, .ackTxStart, .ackTxDone, .irq);
`default_nettype wire

//--- sim/link_engine_cmd_ack_buffers_bench.sv
// Self-checking bench for the link engine front end
`timescale 1ns/100ps
`default_nettype none
module link_engine_cmd_ack_buffers_bench;
  import lecb_pkg::*;
  // Stimulus, valued at time zero
  logic mclk = 1'b0, rst_n = 1'b0, ctrlWrite = 1'b0, engineEnableIn = 1'b0, cmdWrite = 1'b0;
  logic autoMode = 1'b0, packetActive = 1'b0, taskFinished = 1'b0, ramLockOneFree = 1'b1;
  logic ackTxStart = 1'b0, ackTxDone = 1'b0;
  logic [1:0] engineModeIn = 2'h0;
  logic [7:0] cmdData = 8'h00;
  logic [2:0] ackTxEntry = 3'h3, lenReadEntry = 3'h3;
  lecb_len_write_t lenWrite = '0;
  // Observed
  logic engineEnable, queueCmdValid, taskRunning, radioAllowed, timerEventOne, timerEventTwo;
  logic stopRequest, ackSourceBuffers, nextAckRead, payloadSentRead;
  logic [1:0] engineModeSelect;
  logic [2:0] currentTask, ackBufPage;
  logic [5:0] ackBufLen, lenRead0, lenRead1;
  logic [7:0] commandReg, queueCmd;
  logic [15:0] ackBufAddr;
  lecb_irq_t irq;
  logic [8:0] seen = '0;
  int n_mismatch = 0, num_checks = 0;
  lecb_link_engine DUT (.mclk, .rst_n, .ctrlWrite, .engineEnableIn, .engineModeIn, .engineEnable,
    .engineModeSelect, .cmdWrite, .cmdData, .commandReg, .queueCmdValid, .queueCmd, .autoMode,
    .packetActive, .taskFinished, .ramLockOneFree, .currentTask, .taskRunning, .radioAllowed,
    .timerEventOne, .timerEventTwo, .stopRequest, .ackTxStart, .ackTxDone, .ackTxEntry,
    .ackSourceBuffers, .ackBufAddr, .ackBufPage, .ackBufLen, .lenWrite, .lenReadEntry,
    .lenRead0, .lenRead1, .nextAckRead, .payloadSentRead, .irq);
  // Pulses last one cycle, so every one is kept until the next command
  always #50 mclk = ~mclk;
  always @(posedge mclk)
    seen <= seen | {queueCmdValid, stopRequest, timerEventTwo, timerEventOne, irq};
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #10;
  endtask : tick
  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    if (got !== exp) n_mismatch++;
  endtask : chk
  task automatic stop_test(input bit hung = 1'b0);
    if (hung) n_mismatch++;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // One-cycle strobe, then a idle cycle so back-to-back calls never collide
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic ctrl(input logic en, input logic [1:0] md);
    engineEnableIn = en;
    engineModeIn = md;
    pulse(ctrlWrite);
  endtask : ctrl
  // Waits, bounded, for an engine code to be taken unless told to leave it
  task automatic cmd(input logic [7:0] code, input bit hold = 1'b0);
    int i;
    seen = '0;
    cmdData = code;
    pulse(cmdWrite);
    for (i = 0; i < 20 && !hold && commandReg !== 8'h00; i++) tick(1);
    if (i == 20) stop_test(1'b1);
    tick(2);
  endtask : cmd
  task automatic lw(input logic [2:0] e, input logic b, input logic [5:0] l);
    lenWrite = '{1'b1, e, b, l};
    tick(1);
    lenWrite = '0;
    tick(2);
  endtask : lw
  // Engine off: command held, queue code passes, mode only settable while off
  task automatic t_enable();
    chk("idle addr", 16'h6040, ackBufAddr);
    cmd(8'h08, 1'b1);
    cmd(8'h85, 1'b1);
    chk("held", 16'h0885, {commandReg, queueCmd});
    chk("queue", 16'h100, 16'(seen));
    chk("idle", 16'h0, 16'({taskRunning, radioAllowed}));
    ctrl(1'b0, 2'h1);
    ctrl(1'b1, 2'h1);
    ctrl(1'b1, 2'h0);
    tick(3);
    chk("mode", 16'h1, 16'(engineModeSelect));
    chk("rx", 16'h0500, {5'h0, currentTask, commandReg});
    chk("radio", 16'h1, 16'(radioAllowed));
    $display("t_enable done");
  endtask : t_enable
  // Every task start code, each pulse code, then halt
  task automatic t_codes();
    logic [7:0] st [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0a};
    logic [7:0] pc [4] = '{8'h0b, 8'h21, 8'h22, 8'h06};
    logic [15:0] pe [4] = '{16'h080, 16'h020, 16'h040, 16'h002};
    for (int i = 0; i < 7; i++) begin
      cmd(st[i]);
      chk("task", 16'(i + 1), {13'h0, currentTask});
      chk("no pulse", 16'h0, 16'(seen));
    end
    for (int i = 0; i < 4; i++) begin
      cmd(pc[i]);
      chk("pulse", pe[i], 16'(seen));
    end
    cmd(8'h01);
    chk("halt", 16'h0, 16'(currentTask));
    $display("t_codes done");
  endtask : t_codes
  // New task and bad code with a packet on the air, then bad code idle
  task automatic t_abort();
    packetActive = 1'b1;
    cmd(8'h09);
    cmd(8'h08);
    chk("new abort", 16'h001, 16'(seen));
    cmd(8'h07);
    chk("bad busy", 16'h005, 16'(seen));
    chk("stopped", 16'h0, 16'(taskRunning));
    packetActive = 1'b0;
    cmd(8'h40);
    chk("bad idle", 16'h004, 16'(seen));
    $display("t_abort done");
  endtask : t_abort
  // Length handshake, buffer map, one release
  task automatic t_buffers();
    autoMode = 1'b1;
    cmd(8'h08);
    chk("source", 16'h1, 16'(ackSourceBuffers));
    lw(3'h3, 1'b0, 6'h05);
    lw(3'h3, 1'b1, 6'h20);
    chk("lens", 16'h0520, {2'h0, lenRead0, 2'h0, lenRead1});
    for (int e = 0; e < 8; e++) begin
      ackTxEntry = 3'(e);
      tick(2);
      chk("page", e < 2 ? 16'h7 : 16'(e / 2), 16'(ackBufPage));
      chk("addr", 16'h6000 + 16'(e % 2) * 16'h40, ackBufAddr);
    end
    ackTxEntry = 3'h3;
    pulse(ackTxStart);
    seen = '0;
    pulse(ackTxDone);
    tick(1);
    chk("release", 16'h010, 16'(seen));
    chk("lens after", 16'h0020, {2'h0, lenRead0, 2'h0, lenRead1});
    chk("flags", 16'h0101, {7'h0, nextAckRead, 7'h0, payloadSentRead});
    chk("next buf", 16'h6060, ackBufAddr);
    chk("next len", 16'h20, 16'(ackBufLen));
    $display("t_buffers done");
  endtask : t_buffers
  // Flush running, idle without the lock, and behind a payload in flight
  task automatic t_flush();
    cmd(8'h33);
    chk("flush", 16'h008, 16'(seen));
    chk("flushed", 16'h0, 16'({lenRead0, lenRead1, payloadSentRead}));
    chk("next k", 16'h1, 16'(nextAckRead));
    lw(3'h3, 1'b1, 6'h07);
    lw(3'h3, 1'b0, 6'h07);
    pulse(ackTxStart);
    pulse(ackTxDone);
    cmd(8'h01);
    ramLockOneFree = 1'b0;
    cmd(8'h33);
    chk("no lock", 16'h1, 16'({lenRead0, lenRead1, payloadSentRead}));
    cmd(8'h08);
    lw(3'h3, 1'b0, 6'h09);
    pulse(ackTxStart);
    cmd(8'h33, 1'b1);
    tick(2);
    chk("waits", 16'h0033, {7'h0, seen[3], commandReg});
    pulse(ackTxDone);
    tick(3);
    chk("after", 16'h0100, {7'h0, seen[3], commandReg});
    $display("t_flush done");
  endtask : t_flush
  // Enable toggle clears a running task
  task automatic t_toggle();
    cmd(8'h09);
    ctrl(1'b0, 2'h0);
    ctrl(1'b1, 2'h0);
    chk("toggle", 16'h0, 16'({currentTask, taskRunning}));
    cmd(8'h09);
    cmd(8'h0b);
    chk("stop waits", 16'h6, 16'(currentTask));
    pulse(taskFinished);
    chk("graceful", 16'h0, 16'({currentTask, taskRunning}));
    $display("t_toggle done");
  endtask : t_toggle
  // Main sequence after eight cycles of reset
  initial begin
    repeat (8) @(posedge mclk);
    #10;
    chk("reset addr", 16'h6000, ackBufAddr);
    rst_n = 1'b1;
    tick(1);
    t_enable();
    t_codes();
    t_abort();
    t_buffers();
    t_flush();
    t_toggle();
    stop_test();
  end
endmodule : link_engine_cmd_ack_buffers_bench
`default_nettype wire
